/* logic/reset_init_pkg.sv */
package reset_init_pkg;

   // ----------------------------------------
   // Bus geometry
   // ----------------------------------------
   localparam int ADDR_W = 6;
   localparam int DATA_W = 32;

   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam logic [5:0] OFS_CTRL   = 6'h00;
   localparam logic [5:0] OFS_CAUSE  = 6'h04;
   localparam logic [5:0] OFS_MASK   = 6'h08;
   localparam logic [5:0] OFS_LAT    = 6'h0C;
   localparam logic [5:0] OFS_DIR    = 6'h10;
   localparam logic [5:0] OFS_PIN    = 6'h14;
   localparam logic [5:0] OFS_FLAGS  = 6'h18;
   localparam logic [5:0] OFS_STACK  = 6'h1C;
   localparam logic [5:0] OFS_TOS    = 6'h20;

   // ----------------------------------------
   // Control register fields
   // ----------------------------------------
   localparam int CTRL_OSC_LSB = 0;
   localparam int CTRL_OSC_W   = 3;
   localparam int CTRL_HIGH_PRIORITY_GLOBAL_INT_ENABLE    = 3;
   localparam int CTRL_LOW_PRIORITY_GLOBAL_INT_ENABLE    = 4;
   localparam int CTRL_LWE     = 5;
   localparam int CTRL_W       = 6;

   // ----------------------------------------
   // Reset and wake cause bits
   // ----------------------------------------
   localparam int CAUSE_POR      = 0;
   localparam int CAUSE_PIN      = 1;
   localparam int CAUSE_WDT_RST  = 2;
   localparam int CAUSE_INSTR    = 3;
   localparam int CAUSE_STACK    = 4;
   localparam int CAUSE_WAKE_WDT = 5;
   localparam int CAUSE_WAKE_INT = 6;
   localparam int CAUSE_W        = 7;

   // ----------------------------------------
   // Oscillator modes and port A layout
   // ----------------------------------------
   localparam logic [2:0] OSC_EXT_CLOCK_IO = 3'h5;
   localparam logic [2:0] OSC_RC_IO        = 3'h7;
   localparam int         PA_W             = 8;
   localparam int         PA_OPT_BIT       = 6;
   localparam logic [7:0] PA_IMPL_MASK     = 8'h7F;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [5:0] CTRL_RST  = 6'h00;
   localparam logic [6:0] CAUSE_POR_RST = 7'h01;
   localparam logic [6:0] MASK_RST  = 7'h00;
   localparam logic [7:0] LAT_RST   = 8'h00;
   localparam logic [7:0] DIR_RST   = 8'h7F;
   localparam logic [7:0] FLAGS_RST = 8'h00;

   // ----------------------------------------
   // Program counter and return stack
   // ----------------------------------------
   localparam int          PC_W        = 21;
   localparam int          SP_W        = 5;
   localparam int          STACK_DEPTH = 31;
   localparam logic [20:0] VEC_HIGH    = 21'h000008;
   localparam logic [20:0] VEC_LOW     = 21'h000018;
   localparam int          STACK_FULL_BIT = 7;

   typedef enum logic {PWR_RUN, PWR_SLEEP} pwr_state_t;

endpackage

/* logic/return_stack.sv */
module return_stack #(
   parameter int DEPTH = reset_init_pkg::STACK_DEPTH,
   parameter int PC_W  = reset_init_pkg::PC_W,
   parameter int SP_W  = reset_init_pkg::SP_W
) (
   input  wire logic            clk,
   input  wire logic            rst,
   input  wire logic            clear,
   input  wire logic            push,
   input  wire logic [PC_W-1:0] push_value,
   output logic      [SP_W-1:0] sp,
   output logic      [PC_W-1:0] tos,
   output logic                 full
);

   logic [PC_W-1:0] mem [1:DEPTH];
   logic [SP_W-1:0] sp_ff;
   logic            full_ff;

   localparam logic [SP_W-1:0] SP_TOP = SP_W'(DEPTH);

   wire             room    = (sp_ff != SP_TOP);
   wire  [SP_W-1:0] sp_next = sp_ff + 1'b1;

   // ----------------------------------------
   // Pointer; entry zero holds no data
   // ----------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sp_ff   <= '0;
         full_ff <= 1'b0;
      end
      else if (clear)
      begin
         sp_ff <= '0;
      end
      else if (push && room)
      begin
         sp_ff   <= sp_next;
         full_ff <= full_ff | (sp_next == SP_TOP);
      end
   end

   // Once full, further pushes are dropped so the last entry is kept intact
   always_ff @(posedge clk)
   begin
      if (!rst && !clear && push && room)
      begin
         mem[sp_next] <= push_value;
      end
   end

   assign sp   = sp_ff;
   assign full = full_ff;
   assign tos  = (sp_ff == '0) ? '0 : mem[sp_ff];

endmodule // return_stack

/* logic/register_reset_initializer.sv */
module register_reset_initializer #(
   parameter bit HAS_PA_BIT6 = 1'b1
) (
   input  wire logic        CLK,
   input  wire logic        RST,
   input  wire logic [5:0]  AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   input  wire logic [3:0]  AVS_BYTEENABLE,
   output logic      [31:0] AVS_READDATA,
   output logic             AVS_WAITREQUEST,
   input  wire logic        EXT_RESET_PIN_N,
   input  wire logic        WDT_RESET,
   input  wire logic        INSTR_RESET,
   input  wire logic        STACK_RESET,
   input  wire logic        SLEEP_ENTER,
   input  wire logic        WAKE_WDT,
   input  wire logic        WAKE_INT,
   input  wire logic        WAKE_INT_HIGH,
   input  wire logic [7:0]  WAKE_INT_CAUSE,
   input  wire logic [20:0] PC_IN,
   input  wire logic [7:0]  PA_IN,
   output logic      [7:0]  PA_OUT,
   output logic      [7:0]  PA_OE,
   output logic             PC_LOAD,
   output logic      [20:0] PC_VECTOR,
   output logic             SLEEPING,
   output logic             SOFT_RESET,
   output logic             IRQ
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic [reset_init_pkg::CTRL_W-1:0]  ctrl_ff;
   logic [reset_init_pkg::CAUSE_W-1:0] cause_ff;
   logic [reset_init_pkg::CAUSE_W-1:0] mask_ff;
   logic [7:0]                         lat_ff;
   logic [7:0]                         dir_ff;
   logic [7:0]                         flags_ff;
   logic [7:0]                         pin_s1_ff;
   logic [7:0]                         pin_s2_ff;
   logic                               rpin_s1_ff;
   logic                               rpin_s2_ff;
   logic                               wait_ff;
   logic [31:0]                        rdata_ff;
   logic                               pc_load_ff;
   logic [20:0]                        pc_vec_ff;
   logic [7:0]                         pa_out_ff;
   logic [7:0]                         pa_oe_ff;
   logic                               soft_rst_ff;
   logic                               irq_ff;
   reset_init_pkg::pwr_state_t         pwr_ff;
   reset_init_pkg::pwr_state_t         nxt_pwr;

   logic [4:0]  sp;
   logic [20:0] tos;
   logic        stack_full;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         pin_s1_ff  <= 8'h00;
         pin_s2_ff  <= 8'h00;
         rpin_s1_ff <= 1'b1;
         rpin_s2_ff <= 1'b1;
      end
      else
      begin
         pin_s1_ff  <= PA_IN;
         pin_s2_ff  <= pin_s1_ff;
         rpin_s1_ff <= EXT_RESET_PIN_N;
         rpin_s2_ff <= rpin_s1_ff;
      end
   end

   // ----------------------------------------
   // Reset classes and wake events
   // ----------------------------------------
   wire pin_rst  = ~rpin_s2_ff;
   wire soft_rst = pin_rst | WDT_RESET | INSTR_RESET | STACK_RESET;
   wire asleep   = (pwr_ff == reset_init_pkg::PWR_SLEEP);
   wire wake_int = asleep & WAKE_INT & ~soft_rst;
   wire wake_wdt = asleep & WAKE_WDT & ~soft_rst;
   wire high_priority_global_int_enable     = ctrl_ff[reset_init_pkg::CTRL_HIGH_PRIORITY_GLOBAL_INT_ENABLE];
   wire low_priority_global_int_enable     = ctrl_ff[reset_init_pkg::CTRL_LOW_PRIORITY_GLOBAL_INT_ENABLE];
   wire vec_high = WAKE_INT_HIGH & high_priority_global_int_enable;
   wire vec_low  = ~WAKE_INT_HIGH & low_priority_global_int_enable;
   wire vector   = wake_int & (vec_high | vec_low);

   always_comb
   begin
      nxt_pwr = pwr_ff;
      case (pwr_ff)
         reset_init_pkg::PWR_RUN:
            if (SLEEP_ENTER && !soft_rst)
            begin
               nxt_pwr = reset_init_pkg::PWR_SLEEP;
            end
         reset_init_pkg::PWR_SLEEP:
            if (wake_int || wake_wdt || soft_rst)
            begin
               nxt_pwr = reset_init_pkg::PWR_RUN;
            end
         default:
            nxt_pwr = reset_init_pkg::PWR_RUN;
      endcase
   end

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   wire req      = AVS_READ | AVS_WRITE;
   wire done     = req & ~wait_ff;
   wire wr_done  = done & AVS_WRITE & AVS_BYTEENABLE[0];
   wire rd_done  = done & AVS_READ;
   wire sel_ctrl = (AVS_ADDRESS == reset_init_pkg::OFS_CTRL);
   wire sel_caus = (AVS_ADDRESS == reset_init_pkg::OFS_CAUSE);
   wire sel_mask = (AVS_ADDRESS == reset_init_pkg::OFS_MASK);
   wire sel_lat  = (AVS_ADDRESS == reset_init_pkg::OFS_LAT);
   wire sel_dir  = (AVS_ADDRESS == reset_init_pkg::OFS_DIR);
   wire sel_pin  = (AVS_ADDRESS == reset_init_pkg::OFS_PIN);
   wire sel_flag = (AVS_ADDRESS == reset_init_pkg::OFS_FLAGS);
   wire sel_stk  = (AVS_ADDRESS == reset_init_pkg::OFS_STACK);
   wire sel_tos  = (AVS_ADDRESS == reset_init_pkg::OFS_TOS);

   // ----------------------------------------
   // Port A bit 6 gating
   // ----------------------------------------
   wire [2:0] osc_mode = ctrl_ff[reset_init_pkg::CTRL_OSC_LSB +: reset_init_pkg::CTRL_OSC_W];
   wire       io_mode  = (osc_mode == reset_init_pkg::OSC_EXT_CLOCK_IO)
                       | (osc_mode == reset_init_pkg::OSC_RC_IO);
   wire       bit6_ok  = HAS_PA_BIT6 & io_mode;
   wire [7:0] pa_mask  = reset_init_pkg::PA_IMPL_MASK
                       & ~(8'(!bit6_ok) << reset_init_pkg::PA_OPT_BIT);
   wire [7:0] lat_rd   = lat_ff & pa_mask;
   wire [7:0] dir_rd   = dir_ff & pa_mask;
   wire [7:0] pin_rd   = pin_s2_ff & pa_mask;

   wire [31:0] stk_rd  = {24'h000000, stack_full, 2'b00, sp};

   wire [31:0] rd_mux =
        sel_ctrl ? {26'h0000000, ctrl_ff}
      : sel_caus ? {25'h0000000, cause_ff}
      : sel_mask ? {25'h0000000, mask_ff}
      : sel_lat  ? {24'h000000, lat_rd}
      : sel_dir  ? {24'h000000, dir_rd}
      : sel_pin  ? {24'h000000, pin_rd}
      : sel_flag ? {24'h000000, flags_ff}
      : sel_stk  ? stk_rd
      : sel_tos  ? {11'h000, tos}
      : 32'h00000000;

   // ----------------------------------------
   // Next values of the register file
   // ----------------------------------------
   wire [reset_init_pkg::CAUSE_W-1:0] cause_set =
      {wake_int, wake_wdt, STACK_RESET, INSTR_RESET, WDT_RESET, pin_rst, 1'b0};
   wire [reset_init_pkg::CAUSE_W-1:0] cause_clr =
      (rd_done && sel_caus) ? cause_ff : '0;
   // Set wins over the read-clear, so an event in the clearing cycle is kept
   wire [reset_init_pkg::CAUSE_W-1:0] nxt_cause = (cause_ff & ~cause_clr) | cause_set;

   wire [7:0] wd = AVS_WRITEDATA[7:0];
   wire [7:0] flags_wr  = (wr_done && sel_flag) ? wd : flags_ff;
   wire [7:0] nxt_flags = soft_rst ? reset_init_pkg::FLAGS_RST
                        : flags_wr | (wake_int ? WAKE_INT_CAUSE : 8'h00);

   // Long write enable survives watchdog, instruction and stack resets
   wire       lwe_keep  = pin_rst ? 1'b0 : ctrl_ff[reset_init_pkg::CTRL_LWE];
   wire [5:0] ctrl_wr   = (wr_done && sel_ctrl) ? wd[5:0] : ctrl_ff;
   wire [5:0] nxt_ctrl  = soft_rst ? {lwe_keep, 5'h00} : ctrl_wr;

   wire [6:0] nxt_mask  = (wr_done && sel_mask) ? wd[6:0] : mask_ff;
   wire [7:0] nxt_lat   = (wr_done && sel_lat) ? (wd & reset_init_pkg::PA_IMPL_MASK)
                        : lat_ff;
   wire [7:0] nxt_dir   = soft_rst ? reset_init_pkg::DIR_RST
                        : (wr_done && sel_dir) ? (wd & reset_init_pkg::PA_IMPL_MASK)
                        : dir_ff;

   wire [20:0] nxt_vec  = vec_high ? reset_init_pkg::VEC_HIGH : reset_init_pkg::VEC_LOW;

   // ----------------------------------------
   // Register file
   // ----------------------------------------
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         ctrl_ff  <= reset_init_pkg::CTRL_RST;
         cause_ff <= reset_init_pkg::CAUSE_POR_RST;
         mask_ff  <= reset_init_pkg::MASK_RST;
         lat_ff   <= reset_init_pkg::LAT_RST;
         dir_ff   <= reset_init_pkg::DIR_RST;
         flags_ff <= reset_init_pkg::FLAGS_RST;
         pwr_ff   <= reset_init_pkg::PWR_RUN;
      end
      else
      begin
         ctrl_ff  <= nxt_ctrl;
         cause_ff <= nxt_cause;
         mask_ff  <= nxt_mask;
         lat_ff   <= nxt_lat;
         dir_ff   <= nxt_dir;
         flags_ff <= nxt_flags;
         pwr_ff   <= nxt_pwr;
      end
   end

   // ----------------------------------------
   // Bus slave: one wait state on every access
   // ----------------------------------------
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         wait_ff  <= 1'b1;
         rdata_ff <= 32'h00000000;
      end
      else
      begin
         wait_ff  <= ~(req & wait_ff);
         rdata_ff <= (req && wait_ff) ? rd_mux : rdata_ff;
      end
   end

   // ----------------------------------------
   // Wake-up vectoring and outputs
   // ----------------------------------------
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         pc_load_ff  <= 1'b0;
         pc_vec_ff   <= 21'h000000;
         pa_out_ff   <= 8'h00;
         pa_oe_ff    <= 8'h00;
         soft_rst_ff <= 1'b0;
         irq_ff      <= 1'b0;
      end
      else
      begin
         pc_load_ff  <= vector;
         pc_vec_ff   <= vector ? nxt_vec : pc_vec_ff;
         pa_out_ff   <= lat_rd;
         pa_oe_ff    <= ~dir_rd & pa_mask;
         soft_rst_ff <= soft_rst;
         irq_ff      <= |(nxt_cause & nxt_mask);
      end
   end

   return_stack #(
      .DEPTH (reset_init_pkg::STACK_DEPTH),
      .PC_W  (reset_init_pkg::PC_W),
      .SP_W  (reset_init_pkg::SP_W)
   ) u_stack (
      .clk        (CLK),
      .rst        (RST),
      .clear      (soft_rst),
      .push       (vector),
      .push_value (PC_IN),
      .sp         (sp),
      .tos        (tos),
      .full       (stack_full)
   );

   assign AVS_READDATA    = rdata_ff;
   assign AVS_WAITREQUEST = wait_ff;
   assign PA_OUT          = pa_out_ff;
   assign PA_OE           = pa_oe_ff;
   assign PC_LOAD         = pc_load_ff;
   assign PC_VECTOR       = pc_vec_ff;
   assign SLEEPING        = (pwr_ff == reset_init_pkg::PWR_SLEEP);
   assign SOFT_RESET      = soft_rst_ff;
   assign IRQ             = irq_ff;

endmodule // register_reset_initializer

/* dv/port_pins.sv */
module port_pins (
   input  wire logic [7:0] pa_out,
   input  wire logic [7:0] pa_oe,
   output logic      [7:0] pa_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------
   // Board pins
   // ------------------------------
   // Undriven pins float up on pull-ups, so a stale latch value never shows
   assign pa_in = (pa_out & pa_oe) | ~pa_oe;
endmodule // port_pins

/* dv/reset_init_sva.sv */
module reset_init_sva #(
   parameter bit HAS_PA_BIT6 = 1'b1
) (
   input wire logic        CLK,
   input wire logic        RST,
   input wire logic        AVS_READ,
   input wire logic        AVS_WRITE,
   input wire logic [31:0] AVS_READDATA,
   input wire logic        AVS_WAITREQUEST,
   input wire logic        EXT_RESET_PIN_N,
   input wire logic        WDT_RESET,
   input wire logic        INSTR_RESET,
   input wire logic        STACK_RESET,
   input wire logic        SLEEP_ENTER,
   input wire logic        WAKE_WDT,
   input wire logic        WAKE_INT,
   input wire logic        WAKE_INT_HIGH,
   input wire logic [7:0]  PA_OUT,
   input wire logic        PC_LOAD,
   input wire logic [20:0] PC_VECTOR,
   input wire logic        SLEEPING,
   input wire logic        SOFT_RESET
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);
   wire soft_src = WDT_RESET | INSTR_RESET | STACK_RESET;
   // ------------------------------
   // Sequences
   // ------------------------------
   sequence req_new;
      $rose(AVS_READ || AVS_WRITE);
   endsequence
   sequence wake_taken;
      SLEEPING && (WAKE_INT || WAKE_WDT) && !soft_src && !SOFT_RESET;
   endsequence
   sequence sleep_asked;
      SLEEP_ENTER && !SLEEPING && !soft_src && !SOFT_RESET && !WAKE_INT && !WAKE_WDT
         && $past(EXT_RESET_PIN_N, 2);
   endsequence
   // Pin is synchronised, so the reset shows a few cycles after the fall
   sequence pin_held;
      $fell(EXT_RESET_PIN_N) ##1 !EXT_RESET_PIN_N [*3];
   endsequence
   // ------------------------------
   // Assertions
   // ------------------------------
   wait_once_a: assert property (req_new |=> !AVS_WAITREQUEST)
      else $error("bus did not answer after one wait state");
   wait_pulse_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
      else $error("waitrequest low for more than one cycle");
   idle_wait_a: assert property (!(AVS_READ || AVS_WRITE) |=> AVS_WAITREQUEST)
      else $error("waitrequest dropped with no request");
   wake_exit_a: assert property (wake_taken |=> !SLEEPING)
      else $error("sleep not left after wake");
   sleep_entry_a: assert property (sleep_asked |=> SLEEPING)
      else $error("sleep not entered");
   load_cause_a: assert property (PC_LOAD |-> $past(SLEEPING) && $past(WAKE_INT))
      else $error("vector load without interrupt wake");
   vector_pick_a: assert property (PC_LOAD |-> PC_VECTOR == ($past(WAKE_INT_HIGH) ?
      reset_init_pkg::VEC_HIGH : reset_init_pkg::VEC_LOW))
      else $error("wrong interrupt vector");
   load_pulse_a: assert property (PC_LOAD |=> !PC_LOAD)
      else $error("vector load longer than one cycle");
   soft_flag_a: assert property (soft_src |=> SOFT_RESET)
      else $error("soft reset not flagged");
   pin_reset_a: assert property (pin_held |-> ##[0:4] SOFT_RESET)
      else $error("reset pin not acted on");
   bit7_zero_a: assert property (PA_OUT[7] == 1'b0)
      else $error("unimplemented port bit driven");
   bit6_absent_a: assert property (HAS_PA_BIT6 || PA_OUT[6] == 1'b0)
      else $error("absent port bit driven");
   data_width_a: assert property (AVS_READDATA[31:21] == 11'h000)
      else $error("read data upper bits not zero");
endmodule // reset_init_sva
bind register_reset_initializer reset_init_sva #(.HAS_PA_BIT6(HAS_PA_BIT6)) chk (.*);

/* dv/register_reset_initializer_test.sv */
module register_reset_initializer_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        CLK, RST, AVS_READ, AVS_WRITE, EXT_RESET_PIN_N, WDT_RESET, INSTR_RESET;
   logic        STACK_RESET, SLEEP_ENTER, WAKE_WDT, WAKE_INT, WAKE_INT_HIGH;
   logic        AVS_WAITREQUEST, PC_LOAD, SLEEPING, SOFT_RESET, IRQ;
   logic [5:0]  AVS_ADDRESS;
   logic [3:0]  AVS_BYTEENABLE;
   logic [31:0] AVS_WRITEDATA, AVS_READDATA, q;
   logic [7:0]  WAKE_INT_CAUSE, PA_IN, PA_OUT, PA_OE, e;
   logic [20:0] PC_IN, PC_VECTOR;
   logic [7:0]  pa_out_nob6;
   int          error_cnt, check_count;

   register_reset_initializer dut (.*);
   port_pins pins (.pa_out(PA_OUT), .pa_oe(PA_OE), .pa_in(PA_IN));
   // Variant without port A bit 6 shares every input; only its latch pins are compared
   register_reset_initializer #(.HAS_PA_BIT6(1'b0)) dut_nob6 (
      .CLK, .RST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE,
      .AVS_READDATA(), .AVS_WAITREQUEST(), .EXT_RESET_PIN_N, .WDT_RESET, .INSTR_RESET,
      .STACK_RESET, .SLEEP_ENTER, .WAKE_WDT, .WAKE_INT, .WAKE_INT_HIGH, .WAKE_INT_CAUSE,
      .PC_IN, .PA_IN, .PA_OUT(pa_out_nob6), .PA_OE(), .PC_LOAD(), .PC_VECTOR(),
      .SLEEPING(), .SOFT_RESET(), .IRQ());

   initial
   begin
      CLK = 1'b0;
      forever #5 CLK = ~CLK;
   end
   // ------------------------------
   // Tasks
   // ------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Request held until waitrequest is sampled low; the global timeout cuts a hang
   task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
      @(posedge CLK);
      AVS_ADDRESS <= a;
      AVS_WRITE <= wr;
      AVS_READ <= !wr;
      AVS_WRITEDATA <= {24'h000000, d};
      @(posedge CLK);
      while (AVS_WAITREQUEST !== 1'b0)
         @(posedge CLK);
      q = AVS_READDATA;
      AVS_READ <= 1'b0;
      AVS_WRITE <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h00);
      chk(q, {24'h000000, exp});
   endtask
   task automatic wake(input logic hi, input logic wdt, input logic [7:0] c, input logic ld,
                       input logic [20:0] vec);
      @(posedge CLK);
      SLEEP_ENTER <= 1'b1;
      @(posedge CLK);
      SLEEP_ENTER <= 1'b0;
      WAKE_INT <= !wdt;
      WAKE_WDT <= wdt;
      WAKE_INT_HIGH <= hi;
      WAKE_INT_CAUSE <= c;
      @(posedge CLK);
      WAKE_INT <= 1'b0;
      WAKE_WDT <= 1'b0;
      #1;
      chk({31'h0, PC_LOAD}, {31'h0, ld});
      chk({31'h0, SLEEPING}, 32'h0);
      if (ld)
         chk({11'h000, PC_VECTOR}, {11'h000, vec});
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (5000) @(posedge CLK);
      error_cnt++;
      $display("MISMATCH %0t timeout", $time);
      tally_and_finish();
   end
   // ------------------------------
   // Tests
   // ------------------------------
   initial
   begin
      {AVS_READ, AVS_WRITE, WDT_RESET, INSTR_RESET, STACK_RESET, SLEEP_ENTER} = 6'h00;
      {WAKE_WDT, WAKE_INT, WAKE_INT_HIGH, AVS_ADDRESS, AVS_WRITEDATA, WAKE_INT_CAUSE} = '0;
      {error_cnt, check_count, PC_IN} = '0;
      AVS_BYTEENABLE = 4'hF;
      EXT_RESET_PIN_N = 1'b1;
      RST = 1'b1;
      repeat (8) @(posedge CLK);
      RST <= 1'b0;
      rd(reset_init_pkg::OFS_CAUSE, 8'h01);
      rd(reset_init_pkg::OFS_CAUSE, 8'h00);
      rd(reset_init_pkg::OFS_DIR, 8'h3F);
      rd(reset_init_pkg::OFS_CTRL, 8'h00);
      rd(reset_init_pkg::OFS_FLAGS, 8'h00);
      rd(reset_init_pkg::OFS_STACK, 8'h00);
      bus(1'b1, reset_init_pkg::OFS_CTRL, 8'hFF);
      rd(reset_init_pkg::OFS_CTRL, 8'h3F);
      bus(1'b1, 6'h24, 8'hFF);
      rd(6'h24, 8'h00);
      AVS_BYTEENABLE <= 4'hE;
      bus(1'b1, reset_init_pkg::OFS_MASK, 8'hFF);
      AVS_BYTEENABLE <= 4'hF;
      rd(reset_init_pkg::OFS_MASK, 8'h00);
      $display("test reset_values done");
      bus(1'b1, reset_init_pkg::OFS_DIR, 8'h00);
      bus(1'b1, reset_init_pkg::OFS_LAT, 8'hFF);
      for (int m = 0; m < 8; m++)
      begin
         bus(1'b1, reset_init_pkg::OFS_CTRL, 8'(m));
         e = (3'(m) == reset_init_pkg::OSC_EXT_CLOCK_IO || 3'(m) == reset_init_pkg::OSC_RC_IO)
             ? 8'h7F : 8'h3F;
         rd(reset_init_pkg::OFS_LAT, e);
         rd(reset_init_pkg::OFS_PIN, e);
         chk({24'h000000, PA_OUT}, {24'h000000, e});
         chk({24'h000000, PA_OE}, {24'h000000, e});
         chk({24'h000000, pa_out_nob6}, 32'h0000003F);
      end
      $display("test port_bit6 done");
      bus(1'b1, reset_init_pkg::OFS_MASK, 8'h40);
      bus(1'b1, reset_init_pkg::OFS_CTRL, 8'h28);
      PC_IN <= 21'h012345;
      wake(1'b1, 1'b0, 8'h05, 1'b1, reset_init_pkg::VEC_HIGH);
      rd(reset_init_pkg::OFS_STACK, 8'h01);
      bus(1'b0, reset_init_pkg::OFS_TOS, 8'h00);
      chk(q, 32'h00012345);
      rd(reset_init_pkg::OFS_FLAGS, 8'h05);
      chk({31'h0, IRQ}, 32'h1);
      rd(reset_init_pkg::OFS_CAUSE, 8'h40);
      repeat (2) @(posedge CLK);
      chk({31'h0, IRQ}, 32'h0);
      wake(1'b0, 1'b0, 8'h80, 1'b0, reset_init_pkg::VEC_LOW);
      rd(reset_init_pkg::OFS_STACK, 8'h01);
      rd(reset_init_pkg::OFS_FLAGS, 8'h85);
      bus(1'b1, reset_init_pkg::OFS_CTRL, 8'h38);
      PC_IN <= 21'h01ABCD;
      wake(1'b0, 1'b0, 8'h00, 1'b1, reset_init_pkg::VEC_LOW);
      rd(reset_init_pkg::OFS_STACK, 8'h02);
      bus(1'b0, reset_init_pkg::OFS_TOS, 8'h00);
      chk(q, 32'h0001ABCD);
      wake(1'b0, 1'b1, 8'h00, 1'b0, reset_init_pkg::VEC_LOW);
      rd(reset_init_pkg::OFS_STACK, 8'h02);
      rd(reset_init_pkg::OFS_CAUSE, 8'h60);
      $display("test wake done");
      for (int k = 0; k < 3; k++)
      begin
         bus(1'b1, reset_init_pkg::OFS_CTRL, 8'h25);
         @(posedge CLK);
         {STACK_RESET, INSTR_RESET, WDT_RESET} <= 3'(1 << k);
         @(posedge CLK);
         {STACK_RESET, INSTR_RESET, WDT_RESET} <= 3'h0;
         repeat (3) @(posedge CLK);
         rd(reset_init_pkg::OFS_CTRL, 8'h20);
         rd(reset_init_pkg::OFS_DIR, 8'h3F);
         rd(reset_init_pkg::OFS_LAT, 8'h3F);
         rd(reset_init_pkg::OFS_STACK, 8'h00);
         rd(reset_init_pkg::OFS_FLAGS, 8'h00);
         rd(reset_init_pkg::OFS_CAUSE, 8'(4 << k));
      end
      @(posedge CLK);
      EXT_RESET_PIN_N <= 1'b0;
      repeat (6) @(posedge CLK);
      EXT_RESET_PIN_N <= 1'b1;
      repeat (4) @(posedge CLK);
      rd(reset_init_pkg::OFS_CTRL, 8'h00);
      rd(reset_init_pkg::OFS_CAUSE, 8'h02);
      $display("test soft_resets done");
      tally_and_finish();
   end
endmodule // register_reset_initializer_test
